// file: pkg/sasc_cfg.svh
// Purpose: Offsets, field positions, reset values and timing counts of the converter control
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: Functional notes below
// Functional notes
// [R1] Converter runs only while module_on is set; clearing it discards buffered results.
// [R2] With idle_stop set, converter halts while the device is idle.
// [R3] output_format packs the 10-bit result four ways into 16 bits.
// [R4] trigger_source picks internal counter, charge-time, timer5, timer3 or external edge.
// [R5] Source 000: software clearing sample_enable ends sampling and starts conversion.
// [R6] auto_sample set: hardware sets sample_enable after each conversion completes.
// [R7] auto_sample clear: sampling starts only when software writes sample_enable one.
// [R8] sample_enable reads one while acquiring, zero while holding; hardware also drives it.
// [R9] Read-only done bit set by hardware on completion, cleared by hardware otherwise.
// [R10] reference_select picks references; any 1xx behaves as supply and ground.
// [R11] scan_enable steps mux A through scan-selected channels, else fixed mux A select.
// [R12] fill_half_status shows which half is being filled in split mode.
// [R13] interrupt_rate plus one sequences complete before an interrupt is raised.
// [R14] buffer_split makes two alternating 8-word halves, else one 16-word buffer.
// [R15] alternate_sampling: first sample mux A, then alternate mux B and mux A.
// [R16] clock_source_select picks internal RC clock or system-derived conversion clock.
// [R17] auto_sample_time gives sampling of N conversion clock periods, zero allowed.
// [R18] Conversion clock period is divider plus one cycles; 64 and above reserved.
// [R19] Software configures everything first and sets module_on last.
// [R20] Software clears the interrupt flag before choosing interrupt priority.
// [R21] Positive select codes: 0-15 analog inputs, 16 half band gap, 17 band gap.
// [R22] A scan_channel_select bit set includes that channel in the scan.
// [R23] Each result goes to the next slot; pointer rewinds when an interrupt is raised.
`ifndef SASC_CFG_SVH
`define SASC_CFG_SVH
`define SASC_OFF_CON1 12'h000
`define SASC_OFF_CON2 12'h004
`define SASC_OFF_CON3 12'h008
`define SASC_OFF_CHS 12'h00C
`define SASC_OFF_SCAN_CHANNEL_SELECT 12'h010
`define SASC_OFF_BUF 12'h040
`define SASC_CON1_ON 15
`define SASC_CON1_SIDL 13
`define SASC_CON1_AUTO_SAMPLE 2
`define SASC_CON1_SAMPLE_ENABLE 1
`define SASC_CON1_DONE 0
`define SASC_CON1_WMASK 16'hA3E6
`define SASC_CON2_WMASK 16'hE43F
`define SASC_CON3_WMASK 16'h9FFF
`define SASC_CHS_WMASK 16'h9F9F
`define SASC_RESET_VAL 16'h0000
`define SASC_CONV_TADS 12
`define SASC_CONVERSION_CLOCK_DIVIDER_MAX 8'h3F
`define SASC_RC_DIV 8'h03
`define SASC_CH_HALF_BG 5'h10
`define SASC_CH_BG 5'h11
`endif

// file: pkg/sasc_pkg.sv
// Purpose: Types of the converter control
// Assumes: Constants live in sasc_cfg.svh
// Notes: None
package sasc_pkg;
   typedef enum logic [1:0] {
      SASC_OFF = 2'b00,
      SASC_SAMPLE = 2'b01,
      SASC_CONVERT = 2'b10,
      SASC_HOLD = 2'b11
   } sasc_state_e;
   typedef struct packed {
      logic [15:0] con1;
      logic [15:0] con2;
      logic [15:0] con3;
      logic [15:0] chs;
      logic [15:0] scan_channel_select;
      sasc_state_e st;
      logic [7:0] div_cnt;
      logic [4:0] tad_cnt;
      logic [3:0] seq_cnt;
      logic [3:0] wptr;
      logic alt_b;
      logic [3:0] scan_idx;
      logic [4:0] chan;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic irq;
      logic start_conv;
   } sasc_state_s;
endpackage : sasc_pkg

// file: core/sasc_top.sv
// Purpose: Sequencer and registers of a 10-bit SAR converter
// Assumes: Analog core converts in SASC_CONV_TADS periods and presents data on conv_done
// Notes: Single clock; conversion clock is an enable pulse
//
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/1ps
`include "sasc_cfg.svh"
module sasc_top #(
   parameter int CONV_TADS = `SASC_CONV_TADS
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic device_idle,
   input wire logic rc_tick,
   input wire logic charge_time_measurement_event,
   input wire logic timer5_match,
   input wire logic timer3_match,
   input wire logic ext_external_interrupt_zero_edge,
   input wire logic conv_done,
   input wire logic [9:0] conv_data,
   output logic sample_on,
   output logic convert_start,
   output logic [4:0] channel_sel,
   output logic [2:0] ref_sel,
   output logic converter_interrupt_flag
);
   import sasc_pkg::*;
   sasc_state_s q, d;
   logic [15:0] buf_mem [16];
   logic wr_en;
   logic [3:0] wr_idx;
   logic [15:0] wr_val;

   function automatic logic [15:0] fmt(input logic [1:0] f, input logic [9:0] v);
      logic [15:0] r;
      r = 16'h0000;
      unique case (f)
         2'b11: r = {~v[9], v[8:0], 6'h00};
         2'b10: r = {v, 6'h00};
         2'b01: r = {{6{~v[9]}}, ~v[9], v[8:0]};
         2'b00: r = {6'h00, v};
      endcase
      return r;
   endfunction : fmt

   function automatic logic [3:0] next_scan(input logic [15:0] m, input logic [3:0] cur);
      logic [3:0] n;
      logic found;
      n = cur;
      found = 1'b0;
      for (int i = 1; i <= 16; i++) begin
         if (!found && m[4'(cur + 4'(i))]) begin
            n = 4'(cur + 4'(i));
            found = 1'b1;
         end
      end
      return n;
   endfunction : next_scan

   logic run, tad_tick, trig, sw_clear_sample_enable, sw_set_sample_enable, wr_acc, rd_acc;
   logic [7:0] div_lim;

   always_comb begin
      wr_acc = psel && penable && pwrite && q.pready;
      rd_acc = psel && !penable;
      run = q.con1[`SASC_CON1_ON] && !(q.con1[`SASC_CON1_SIDL] && device_idle); // [R1] [R2]
      div_lim = (q.con3[7:0] > `SASC_CONVERSION_CLOCK_DIVIDER_MAX) ? `SASC_CONVERSION_CLOCK_DIVIDER_MAX : q.con3[7:0]; // [R18]
      if (q.con3[15]) begin
         div_lim = `SASC_RC_DIV; // [R16]
      end
      tad_tick = q.con3[15] ? rc_tick : (q.div_cnt >= div_lim); // [R16] [R18]
      unique case (q.con1[7:5]) // [R4]
         3'b111: trig = q.tad_cnt >= q.con3[12:8]; // [R17]
         3'b110: trig = charge_time_measurement_event;
         3'b100: trig = timer5_match;
         3'b010: trig = timer3_match;
         3'b001: trig = ext_external_interrupt_zero_edge;
         default: trig = 1'b0;
      endcase
      sw_clear_sample_enable = wr_acc && paddr == `SASC_OFF_CON1 && !pwdata[`SASC_CON1_SAMPLE_ENABLE];
      sw_set_sample_enable = wr_acc && paddr == `SASC_OFF_CON1 && pwdata[`SASC_CON1_SAMPLE_ENABLE];
   end

   always_comb begin
      d = q;
      d.pready = 1'b0;
      d.pslverr = 1'b0;
      d.irq = 1'b0;
      d.start_conv = 1'b0;
      wr_en = 1'b0;
      wr_idx = 4'h0;
      wr_val = 16'h0000;
      if (rd_acc) begin
         d.pready = 1'b1;
         d.prdata = 32'h0000_0000;
         unique case (paddr)
            `SASC_OFF_CON1: d.prdata[15:0] = q.con1; // [R8] [R9]
            `SASC_OFF_CON2: d.prdata[15:0] = q.con2; // [R12]
            `SASC_OFF_CON3: d.prdata[15:0] = q.con3;
            `SASC_OFF_CHS: d.prdata[15:0] = q.chs;
            `SASC_OFF_SCAN_CHANNEL_SELECT: d.prdata[15:0] = q.scan_channel_select;
            default: begin
               if (paddr[11:6] == 6'h01 && paddr[1:0] == 2'b00) begin
                  d.prdata[15:0] = buf_mem[paddr[5:2]];
               end else begin
                  d.pslverr = !pwrite;
               end
            end
         endcase
         if (pwrite) begin
            d.prdata = 32'h0000_0000;
            d.pslverr = !(paddr == `SASC_OFF_CON1 || paddr == `SASC_OFF_CON2 ||
               paddr == `SASC_OFF_CON3 || paddr == `SASC_OFF_CHS || paddr == `SASC_OFF_SCAN_CHANNEL_SELECT);
         end
      end
      if (wr_acc) begin
         unique case (paddr)
            `SASC_OFF_CON1: d.con1 = (pwdata[15:0] & `SASC_CON1_WMASK) |
               (q.con1 & ~`SASC_CON1_WMASK);
            `SASC_OFF_CON2: d.con2 = (pwdata[15:0] & `SASC_CON2_WMASK) |
               (q.con2 & ~`SASC_CON2_WMASK);
            `SASC_OFF_CON3: d.con3 = pwdata[15:0] & `SASC_CON3_WMASK;
            `SASC_OFF_CHS: d.chs = pwdata[15:0] & `SASC_CHS_WMASK;
            `SASC_OFF_SCAN_CHANNEL_SELECT: d.scan_channel_select = pwdata[15:0];
            default: d.scan_channel_select = q.scan_channel_select;
         endcase
      end
      d.div_cnt = (tad_tick || q.con3[15] || !run) ? 8'h00 : 8'(q.div_cnt + 8'h01);
      d.con1[`SASC_CON1_DONE] = 1'b0; // [R9]
      unique case (q.st)
         SASC_OFF: begin
            d.tad_cnt = 5'h00;
            d.alt_b = 1'b0;
            if (run) begin
               d.st = SASC_HOLD;
               d.chan = q.chs[4:0];
            end
         end
         SASC_HOLD: begin
            d.con1[`SASC_CON1_SAMPLE_ENABLE] = 1'b0;
            if (sw_set_sample_enable || q.con1[`SASC_CON1_AUTO_SAMPLE]) begin // [R6] [R7]
               d.st = SASC_SAMPLE;
               d.tad_cnt = 5'h00;
               d.con1[`SASC_CON1_SAMPLE_ENABLE] = 1'b1; // [R8]
            end
         end
         SASC_SAMPLE: begin
            if (tad_tick && q.tad_cnt != 5'h1F) begin
               d.tad_cnt = 5'(q.tad_cnt + 5'h01);
            end
            if ((q.con1[7:5] == 3'b000 && sw_clear_sample_enable) || trig) begin // [R5]
               d.st = SASC_CONVERT;
               d.start_conv = 1'b1;
               d.con1[`SASC_CON1_SAMPLE_ENABLE] = 1'b0; // [R8]
            end else begin
               d.con1[`SASC_CON1_SAMPLE_ENABLE] = 1'b1;
            end
         end
         SASC_CONVERT: begin
            d.con1[`SASC_CON1_SAMPLE_ENABLE] = 1'b0;
            if (conv_done) begin
               wr_en = 1'b1; // [R23]
               wr_val = fmt(q.con1[9:8], conv_data); // [R3]
               wr_idx = q.con2[1] ? {q.con2[7], q.wptr[2:0]} : q.wptr; // [R14]
               d.con1[`SASC_CON1_DONE] = 1'b1; // [R9]
               d.wptr = 4'(q.wptr + 4'h1);
               d.seq_cnt = 4'(q.seq_cnt + 4'h1);
               if (q.seq_cnt == q.con2[5:2]) begin // [R13]
                  d.seq_cnt = 4'h0;
                  d.wptr = 4'h0; // [R23]
                  d.irq = 1'b1;
                  if (q.con2[1]) begin
                     d.con2[7] = ~q.con2[7]; // [R12] [R14]
                  end
               end
               d.alt_b = q.con2[0] ? ~q.alt_b : 1'b0; // [R15]
               if (q.con2[10]) begin
                  d.scan_idx = next_scan(q.scan_channel_select, q.scan_idx); // [R11] [R22]
               end
               d.st = SASC_HOLD;
               d.tad_cnt = 5'h00;
               if (q.con1[`SASC_CON1_AUTO_SAMPLE]) begin
                  d.st = SASC_SAMPLE; // [R6]
                  d.con1[`SASC_CON1_SAMPLE_ENABLE] = 1'b1;
               end
            end
         end
      endcase
      if (q.con2[0] && q.alt_b) begin
         d.chan = q.chs[12:8]; // [R15] [R21]
      end else if (q.con2[10]) begin
         d.chan = {1'b0, q.scan_idx}; // [R11]
      end else begin
         d.chan = q.chs[4:0]; // [R21]
      end
      if (!run) begin
         d.st = SASC_OFF; // [R1] [R2]
         d.con1[`SASC_CON1_SAMPLE_ENABLE] = 1'b0;
         d.start_conv = 1'b0;
         d.seq_cnt = 4'h0;
         d.wptr = 4'h0;
         d.scan_idx = next_scan(q.scan_channel_select, 4'hF); // [R11] [R22]
         d.con2[7] = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   always_ff @(posedge pclk) begin
      if (!q.con1[`SASC_CON1_ON]) begin
         for (int i = 0; i < 16; i++) begin
            buf_mem[i] <= 16'h0000; // [R1]
         end
      end else if (wr_en) begin
         buf_mem[wr_idx] <= wr_val;
      end
   end

   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;
   assign sample_on = q.con1[`SASC_CON1_SAMPLE_ENABLE];
   assign convert_start = q.start_conv;
   assign channel_sel = q.chan;
   assign ref_sel = q.con2[15] ? 3'b000 : q.con2[15:13]; // [R10]
   assign converter_interrupt_flag = q.irq;

   AST_SAMPLE_ENABLE_ON_AUTO_SAMPLE: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
      (q.st == SASC_CONVERT && conv_done && q.con1[`SASC_CON1_AUTO_SAMPLE] && run)
      |=> sample_on) else $error("auto sample did not restart");
   AST_START_ON_CLEAR: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
      (q.st == SASC_SAMPLE && q.con1[7:5] == 3'b000 && sw_clear_sample_enable && run)
      |=> convert_start && !sample_on) else $error("clear did not start conversion");
   AST_OFF_IDLE: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
      (q.con1[`SASC_CON1_ON] && q.con1[`SASC_CON1_SIDL] && device_idle)
      |=> q.st == SASC_OFF) else $error("idle stop ignored");
   AST_DONE_PULSE: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
      q.con1[`SASC_CON1_DONE] |-> $past(conv_done) && $past(q.st) == SASC_CONVERT)
      else $error("done without conversion");
   AST_IRQ_RATE: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
      converter_interrupt_flag |-> q.seq_cnt == 4'h0 && q.wptr == 4'h0)
      else $error("interrupt without rewind");
   AST_REF_HIGH: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
      q.con2[15] |-> ref_sel == 3'b000) else $error("reference 1xx not default");
   AST_NO_SAMPLE_ENABLE_HOLD: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
      (q.st == SASC_HOLD && !q.con1[`SASC_CON1_AUTO_SAMPLE] && !sw_set_sample_enable) |=> !sample_on)
      else $error("sampling started without request");
   AST_SPLIT_TOGGLE: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
      (converter_interrupt_flag && q.con2[1] && run) |-> q.con2[7] != $past(q.con2[7]))
      else $error("fill half did not swap");

   AST_OFF_NO_SAMPLE_ENABLE: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
      !q.con1[`SASC_CON1_ON] |=> !sample_on) else $error("sampling while off");

   AST_OFF_NO_START: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
      !q.con1[`SASC_CON1_ON] |=> !convert_start) else $error("start while off");

   AST_OFF_PTR: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
      !q.con1[`SASC_CON1_ON] |=> q.wptr == 4'h0 && q.seq_cnt == 4'h0)
      else $error("pointers kept while off");

   AST_IDLE_NO_START: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
      (q.con1[`SASC_CON1_SIDL] && device_idle) |=> !convert_start)
      else $error("start during idle stop");

   AST_FMT_INT: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
      (wr_en && q.con1[9:8] == 2'b00) |-> wr_val[15:10] == 6'h00)
      else $error("integer format not zero extended");

   AST_FMT_FRAC: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
      (wr_en && q.con1[9]) |-> wr_val[5:0] == 6'h00)
      else $error("fractional format not left justified");

   AST_FMT_SIGN: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
      (wr_en && q.con1[9:8] == 2'b01) |-> wr_val[15:10] == {6{wr_val[9]}})
      else $error("signed format not sign extended");

   AST_RESERVED_SRC: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
      (q.st == SASC_SAMPLE && (q.con1[7:5] == 3'b101 || q.con1[7:5] == 3'b011))
      |=> !convert_start) else $error("reserved source started conversion");

   AST_START_ONE: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
      convert_start |=> !convert_start) else $error("start longer than one cycle");

   AST_START_FROM_SAMPLE: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
      convert_start |-> $past(q.st) == SASC_SAMPLE) else $error("start outside sampling");

   AST_CONVERT_NO_SAMPLE_ENABLE: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
      q.st == SASC_CONVERT |-> !sample_on) else $error("sampling during conversion");

   AST_SAMPLE_ON: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
      q.st == SASC_SAMPLE |-> sample_on) else $error("sample bit low while sampling");

   AST_DONE_ONE: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
      q.con1[`SASC_CON1_DONE] |=> !q.con1[`SASC_CON1_DONE])
      else $error("done bit not cleared");

   AST_DONE_WRITE: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
      wr_en |=> q.con1[`SASC_CON1_DONE]) else $error("done bit not set");

   AST_REF_LOW: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
      !q.con2[15] |-> ref_sel == q.con2[15:13]) else $error("reference not passed");

   AST_SCAN_RANGE: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
      (q.con2[10] && !q.con2[0]) |=> !channel_sel[4]) else $error("scan left inputs");

   AST_MUX_A_FIXED: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
      (!q.con2[10] && !q.con2[0]) |=> channel_sel == $past(q.chs[4:0]))
      else $error("fixed mux A not used");

   AST_FILL_OFF: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
      !q.con1[`SASC_CON1_ON] |=> !q.con2[7]) else $error("fill half kept while off");

   AST_IRQ_ONE: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
      converter_interrupt_flag |=> !converter_interrupt_flag)
      else $error("interrupt longer than one cycle");

   AST_IRQ_FROM_DONE: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
      converter_interrupt_flag |-> q.con1[`SASC_CON1_DONE])
      else $error("interrupt without completion");

   AST_SPLIT_IDX: assert property (@(posedge pclk) disable iff (!presetn) // [R14]
      (wr_en && q.con2[1]) |-> wr_idx[3] == q.con2[7]) else $error("wrong buffer half");

   AST_ALT_FIRST: assert property (@(posedge pclk) disable iff (!presetn) // [R15]
      q.st == SASC_OFF |=> !q.alt_b) else $error("alternate not restarted on mux A");

   AST_RC_NO_DIV: assert property (@(posedge pclk) disable iff (!presetn) // [R16]
      q.con3[15] |=> q.div_cnt == 8'h00) else $error("divider runs on RC clock");

   AST_AUTO_SAMPLE_TIME_WAIT: assert property (@(posedge pclk) disable iff (!presetn) // [R17]
      (q.st == SASC_SAMPLE && q.con1[7:5] == 3'b111 && q.tad_cnt < q.con3[12:8])
      |=> !convert_start) else $error("sampling cut short");

   AST_DIV_RANGE: assert property (@(posedge pclk) disable iff (!presetn) // [R18]
      q.div_cnt <= `SASC_CONVERSION_CLOCK_DIVIDER_MAX) else $error("divider beyond limit");

   AST_WRITE_ON_DONE: assert property (@(posedge pclk) disable iff (!presetn) // [R23]
      wr_en |-> q.st == SASC_CONVERT && conv_done) else $error("stray buffer write");

endmodule : sasc_top

// file: bench/sasc_core_model.sv
// Purpose: Stand-in for the analog sample/hold and SAR core
// Assumes: A result is ready LAT plus one cycles after convert_start
// Notes: Outside a result the data lines show the inverted last value
`timescale 1ns/1ps
module sasc_core_model #(
   parameter int LAT = 6
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic convert_start,
   input wire logic [9:0] next_data,
   output logic conv_done,
   output logic [9:0] conv_data
);
   logic [7:0] cnt_q;
   logic [9:0] last_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 8'h00;
         last_q <= 10'h155;
         conv_done <= 1'b0;
         conv_data <= 10'h2AA;
      end else begin
         conv_done <= cnt_q == 8'h01;
         conv_data <= (cnt_q == 8'h01) ? next_data : ~last_q;
         last_q <= (cnt_q == 8'h01) ? next_data : last_q;
         cnt_q <= convert_start ? 8'(LAT) : ((cnt_q != 8'h00) ? cnt_q - 8'h01 : 8'h00);
      end
   end
endmodule : sasc_core_model

// file: bench/tb_top.sv
// Purpose: Self-checking bench of the converter sequencer
// Assumes: Zero-wait APB slave, core model answers after LAT plus one cycles
// Notes: Pulse outputs are counted by a monitor
`timescale 1ns/1ps
`include "sasc_cfg.svh"
module tb_top;
   localparam logic [11:0] A1 = `SASC_OFF_CON1;
   localparam logic [11:0] A2 = `SASC_OFF_CON2;
   localparam logic [11:0] A3 = `SASC_OFF_CON3;
   localparam logic [11:0] AH = `SASC_OFF_CHS;
   localparam logic [11:0] AS = `SASC_OFF_SCAN_CHANNEL_SELECT;
   localparam logic [11:0] AB = `SASC_OFF_BUF;
   localparam logic [2:0] CODE [4] = '{3'b110, 3'b100, 3'b010, 3'b001};
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ev, device_idle, rc_tick;
   logic conv_done, sample_on, convert_start, converter_interrupt_flag;
   logic [3:0] trg;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rv;
   logic [9:0] conv_data, nd;
   logic [4:0] channel_sel, last_chan;
   logic [2:0] ref_sel;
   int fail_count, checks, n_start, n_done, n_irq, slen, last_len, i0, k;
   sasc_top #(.CONV_TADS(`SASC_CONV_TADS)) u_sasc_top (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .device_idle(device_idle),
      .rc_tick(rc_tick), .charge_time_measurement_event(trg[3]), .timer5_match(trg[2]), .timer3_match(trg[1]),
      .ext_external_interrupt_zero_edge(trg[0]), .conv_done(conv_done), .conv_data(conv_data),
      .sample_on(sample_on), .convert_start(convert_start), .channel_sel(channel_sel),
      .ref_sel(ref_sel), .converter_interrupt_flag(converter_interrupt_flag));
   sasc_core_model #(.LAT(6)) u_sasc_core_model (.pclk(pclk), .presetn(presetn),
      .convert_start(convert_start), .next_data(nd), .conv_done(conv_done),
      .conv_data(conv_data));
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      if (convert_start === 1'b1) begin
         n_start++;
         last_chan = channel_sel;
         last_len = slen;
      end
      slen = (sample_on === 1'b1) ? slen + 1 : 0;
      if (conv_done === 1'b1) n_done++;
      if (converter_interrupt_flag === 1'b1) n_irq++;
   end
   task automatic test_done;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : test_done
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rv = prdata;
      ev = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rv, e);
   endtask : rdc
   task automatic wt(ref int c, input int tgt);
      int n;
      n = 0;
      while (c < tgt && n < 3000) begin
         @(posedge pclk);
         n++;
      end
      repeat (3) @(posedge pclk);
   endtask : wt
   task automatic conv(input logic [31:0] c, input logic [9:0] d);
      nd <= d;
      wr(A1, c);
      wr(A1, c | 32'h2);
      chk({31'h0, sample_on}, 32'h1);
      wr(A1, c);
      wt(n_done, n_done + 1);
   endtask : conv
   task automatic pulse(input int j);
      trg <= 4'b1000 >> j;
      @(posedge pclk);
      trg <= 4'h0;
      repeat (3) @(posedge pclk);
   endtask : pulse
   function automatic logic [15:0] fmt(input int f, input logic [9:0] d);
      case (f)
         0: return {6'h00, d};
         1: return {{7{~d[9]}}, d[8:0]};
         2: return {d, 6'h00};
         default: return {~d[9], d[8:0], 6'h00};
      endcase
   endfunction : fmt
   initial begin
      {psel, penable, pwrite, device_idle, rc_tick, trg} = '0;
      paddr = 12'h000;
      pwdata = 32'h0;
      nd = 10'h000;
      presetn = 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdc(A1, 32'h0);
      rdc(A2, 32'h0);
      apb(1'b0, 12'h0FC, 32'h0);
      chk({31'h0, ev}, 32'h1);
      wr(A3, 32'hFFFF);
      rdc(A3, 32'h9FFF);
      wr(A2, 32'hFFFF);
      rdc(A2, 32'hE43F);
      for (int v = 0; v < 8; v++) begin
         wr(A2, 32'(v) << 13);
         chk({29'h0, ref_sel}, v > 3 ? 32'h0 : 32'(v));
      end
      wr(A3, 32'h0);
      wr(AH, 32'h0011);
      wr(A2, 32'h0);
      for (int f = 0; f < 4; f++) begin
         conv(32'h8000 | 32'(f) << 8, 10'h13A);
         chk({27'h0, last_chan}, 32'h11);
         chk(32'(n_irq), 32'(f + 1));
         rdc(AB, {16'h0, fmt(f, 10'h13A)});
      end
      wr(A2, 32'h2);
      conv(32'h8000, 10'h0AA);
      rdc(A2, 32'h82);
      rdc(AB, 32'hAA);
      conv(32'h8000, 10'h055);
      rdc(A2, 32'h2);
      rdc(AB + 12'h020, 32'h55);
      wr(A2, 32'hC);
      i0 = n_irq;
      for (int i = 0; i < 4; i++) begin
         conv(32'h8000, 10'(i + 1));
         chk(32'(n_irq - i0), i == 3 ? 32'h1 : 32'h0);
      end
      rdc(AB + 12'h00C, 32'h4);
      wr(A1, 32'h0);
      rdc(AB, 32'h0);
      wr(AH, 32'h0703);
      wr(AS, 32'h0022);
      for (int m = 0; m < 2; m++) begin
         wr(A1, 32'h0);
         wr(A2, m == 1 ? 32'h043C : 32'h003D);
         for (int i = 0; i < 3; i++) begin
            conv(32'h8000, 10'h0);
            chk({27'h0, last_chan}, 32'((m == 1) ? (i == 1 ? 5 : 1) : (i == 1 ? 7 : 3)));
         end
      end
      wr(A2, 32'h0);
      for (int t = 0; t < 4; t++) begin
         wr(A1, 32'h8002 | 32'(CODE[t]) << 5);
         i0 = n_start;
         for (int j = 0; j < 4; j++) if (j != t) pulse(j);
         chk(32'(n_start - i0), 32'h0);
         pulse(t);
         chk(32'(n_start - i0), 32'h1);
         wt(n_done, n_done + 1);
      end
      wr(A1, 32'h0);
      wr(A3, 32'h0403);
      i0 = n_done;
      wr(A1, 32'h80E4);
      wt(n_done, i0 + 3);
      chk(32'(n_done - i0 >= 3), 32'h1);
      chk(32'(last_len > 11 && last_len < 23), 32'h1);
      wr(A1, 32'hA0E4);
      device_idle <= 1'b1;
      repeat (40) @(posedge pclk);
      i0 = n_start;
      repeat (200) @(posedge pclk);
      chk(32'(n_start - i0), 32'h0);
      device_idle <= 1'b0;
      wr(A1, 32'h0);
      wr(A3, 32'h8200);
      wr(A1, 32'h80E4);
      i0 = n_start;
      repeat (100) @(posedge pclk);
      chk(32'(n_start - i0), 32'h0);
      k = 0;
      while (n_start == i0 && k < 9) begin
         rc_tick <= 1'b1;
         @(posedge pclk);
         rc_tick <= 1'b0;
         repeat (4) @(posedge pclk);
         k++;
      end
      chk(32'(k >= 2 && k <= 3), 32'h1);
      test_done();
   end
   initial begin
      #200000;
      fail_count++;
      $display("mismatch at %0t: watchdog expired", $time);
      test_done();
   end
endmodule : tb_top
